// ==== rtl/lpsr_regs.svh ====
`ifndef LPSR_REGS_SVH
`define LPSR_REGS_SVH
// width of one transfer in bits
`define LPSR_WORD_BITS 8
// bit counter reset and last values
`define LPSR_CNT_ZERO 3'h0
`define LPSR_CNT_LAST 3'h7
// expected word, arbitrary default
`define LPSR_EXPECT_DEF 8'hA5
// ready indicator levels
`define LPSR_READY_LVL 1'h0
`define LPSR_BUSY_LVL 1'h1
`endif

// ==== rtl/lpsr_pkg.sv ====
package lpsr_pkg;
  // power states, gray coded along run, stop, snooze, wake
  typedef enum logic [1:0] {
    LPSR_RUN = 2'h0,
    LPSR_STOP = 2'h1,
    LPSR_SNOOZE = 2'h3,
    LPSR_WAKE = 2'h2
  } lpsr_state_t;
  // a finished word from the shifter
  typedef struct packed {
    logic done;
    logic [7:0] data;
  } lpsr_word_t;
endpackage : lpsr_pkg

// ==== rtl/lpsr_shift.sv ====
`timescale 1ns/1ps
`include "lpsr_regs.svh"
module lpsr_shift
  import lpsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic sclk_rise_i,
  input wire logic sdat_i,
  output lpsr_word_t word_o
);
  logic [2:0] cnt_ff;
  logic [7:0] sh_ff;
  logic done_ff;
  wire [7:0] nxt_sh = {sh_ff[6:0], sdat_i};
  wire last_bit = (cnt_ff == `LPSR_CNT_LAST);
  wire take = en_i & sclk_rise_i;
  // msb first, one bit per rising edge of the shift clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_i) begin
      cnt_ff <= `LPSR_CNT_ZERO;
      done_ff <= 1'h0;
    end else begin
      done_ff <= take & last_bit;
      if (take) begin
        cnt_ff <= cnt_ff + 3'h1;
        sh_ff <= nxt_sh;
      end
    end
  end
  assign word_o = '{done: done_ff, data: sh_ff};
endmodule : lpsr_shift

// ==== rtl/lpsr_slave.sv ====
`timescale 1ns/1ps
`include "lpsr_regs.svh"
// Functional notes
// - ready output low ready, high busy
// - sleep receive enable needs fast oscillator clock
// - falling clock in stop enters snooze
// - configure and arm, then ready low
// - shift clock taken from external pin
// - compare word with expected, drive match
// - receive end wakes cpu back to run
// - eight bits, msb first, phase type 1
// - after word read, drive ready high
module lpsr_slave
  import lpsr_pkg::*;
#(
  parameter logic [7:0] EXPECT = `LPSR_EXPECT_DEF
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic FAST_OSC_SEL_I,
  input wire logic SLEEP_RX_EN_I,
  input wire logic STOP_REQ_I,
  input wire logic WORD_READ_I,
  input wire logic SLAVE_CLOCK_IN_I,
  input wire logic SLAVE_DATA_IN_I,
  output logic BUSY_O,
  output logic MATCH_O,
  output logic RECEIVE_END_IRQ_O,
  output logic CPU_HALT_O,
  output logic [7:0] RX_DATA_O
);
  logic [1:0] clk_sync_ff;
  logic [1:0] dat_sync_ff;
  logic clk_old_ff;
  lpsr_state_t state_ff;
  lpsr_state_t nxt_state;
  logic busy_ff;
  logic match_ff;
  logic irq_ff;
  logic halt_ff;
  logic [7:0] data_ff;
  lpsr_word_t word;

  // pins pass two flops; clock edges found from the second stage only
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      clk_sync_ff <= 2'h3;
      dat_sync_ff <= 2'h0;
      clk_old_ff <= 1'h1;
    end else begin
      clk_sync_ff <= {clk_sync_ff[0], SLAVE_CLOCK_IN_I};
      dat_sync_ff <= {dat_sync_ff[0], SLAVE_DATA_IN_I};
      clk_old_ff <= clk_sync_ff[1];
    end
  end

  wire sclk_fall = clk_old_ff & ~clk_sync_ff[1];
  wire sclk_rise = ~clk_old_ff & clk_sync_ff[1];
  // arming without the fast oscillator is simply ignored
  wire armed = SLEEP_RX_EN_I & FAST_OSC_SEL_I;
  wire rx_en = (state_ff == LPSR_STOP) | (state_ff == LPSR_SNOOZE);

  // type 1 phase: data driven on falling edge, sampled on rising
  lpsr_shift u_shift (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .en_i(rx_en),
    .sclk_rise_i(sclk_rise),
    .sdat_i(dat_sync_ff[1]),
    .word_o(word)
  );

  // power state sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LPSR_RUN: if (STOP_REQ_I && armed) nxt_state = LPSR_STOP;
      LPSR_STOP: begin
        if (!armed) nxt_state = LPSR_RUN;
        else if (sclk_fall) nxt_state = LPSR_SNOOZE;
      end
      LPSR_SNOOZE: if (word.done) nxt_state = LPSR_WAKE;
      LPSR_WAKE: if (WORD_READ_I) nxt_state = LPSR_RUN;
    endcase
  end

  wire go_stop = (state_ff == LPSR_RUN) & (nxt_state == LPSR_STOP);
  wire go_wake = (state_ff == LPSR_SNOOZE) & word.done;
  wire rd_done = (state_ff == LPSR_WAKE) & WORD_READ_I;

  // state and ready indicator; busy from reset so master holds off
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      state_ff <= LPSR_RUN;
      busy_ff <= `LPSR_BUSY_LVL;
      halt_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      if (go_stop) busy_ff <= `LPSR_READY_LVL;
      else if (rd_done) busy_ff <= `LPSR_BUSY_LVL;
      else if (nxt_state == LPSR_RUN) busy_ff <= `LPSR_BUSY_LVL;
      halt_ff <= (nxt_state == LPSR_STOP) | (nxt_state == LPSR_SNOOZE);
    end
  end

  // capture word, compare, pulse receive end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      data_ff <= 8'h00;
      match_ff <= 1'h0;
      irq_ff <= 1'h0;
    end else begin
      irq_ff <= go_wake;
      if (go_wake) begin
        data_ff <= word.data;
        match_ff <= (word.data == EXPECT);
      end
    end
  end

  assign BUSY_O = busy_ff;
  assign MATCH_O = match_ff;
  assign RECEIVE_END_IRQ_O = irq_ff;
  assign CPU_HALT_O = halt_ff;
  assign RX_DATA_O = data_ff;
endmodule : lpsr_slave

// ==== bench/lpsr_chk_assertions.sv ====
`timescale 1ns/1ps
module lpsr_chk #(parameter logic [7:0] EXPECT = 8'h00) (
  input logic CORE_CLK_I, RST_N_I, FAST_OSC_SEL_I, SLEEP_RX_EN_I, STOP_REQ_I,
  input logic WORD_READ_I, BUSY_O, MATCH_O, CPU_HALT_O, RECEIVE_END_IRQ_O,
  input logic [7:0] RX_DATA_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // r is awake with busy shown; arming only counts on the fast oscillator
  wire b = BUSY_O, h = CPU_HALT_O, i = RECEIVE_END_IRQ_O, m = MATCH_O;
  wire a = FAST_OSC_SEL_I & SLEEP_RX_EN_I, r = b & !h, d = WORD_READ_I;
  property p_st; r && a && STOP_REQ_I |=> !b && h; endproperty
  a_st: assert property (p_st) else $error("stop entry");
  property p_os; r && !FAST_OSC_SEL_I |=> r; endproperty
  a_os: assert property (p_os) else $error("slow clock");
  property p_hl; $rose(h) |-> $past(STOP_REQ_I && a); endproperty
  a_hl: assert property (p_hl) else $error("halt cause");
  property p_wk; i |-> !h && $past(h) ##1 !i; endproperty
  a_wk: assert property (p_wk) else $error("wake");
  property p_mt; i |-> m == (RX_DATA_O == EXPECT); endproperty
  a_mt: assert property (p_mt) else $error("match");
  property p_hd; !i |-> $stable(RX_DATA_O) && $stable(m); endproperty
  a_hd: assert property (p_hd) else $error("word hold");
  property p_rd; d && !b && !h |=> b; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_bz; !b && a && !d |=> !b; endproperty
  a_bz: assert property (p_bz) else $error("ready");
  c_m: cover property (i && m);
  c_n: cover property (i && !m);
  c_r: cover property (d && !b);
endmodule : lpsr_chk
bind lpsr_slave lpsr_chk #(.EXPECT(EXPECT)) chk_u (.*);

// ==== bench/lpsr_mst.sv ====
`timescale 1ns/1ps
// master: clock idles high and stands still between words
module lpsr_mst (
  input wire logic busy_i,
  output logic sck_o = 1'h1,
  output logic sdi_o = 1'h0
);
  task automatic send(input logic [7:0] b);
    wait (busy_i === 1'h0);
    for (int k = 7; k >= 0; k--) begin
      #160 {sck_o, sdi_o} = {1'h0, b[k]};
      #160 sck_o = 1'h1;
    end
    #160 sdi_o = ~b[0]; // released line must not keep the last bit
  endtask : send
endmodule : lpsr_mst

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] EXPECT = 8'h3C;
  logic CORE_CLK_I = 0, RST_N_I = 0, FAST_OSC_SEL_I = 0, SLEEP_RX_EN_I = 1;
  logic STOP_REQ_I = 1, WORD_READ_I = 0, SLAVE_CLOCK_IN_I, SLAVE_DATA_IN_I;
  logic BUSY_O, MATCH_O, RECEIVE_END_IRQ_O, CPU_HALT_O;
  logic [7:0] RX_DATA_O;
  logic [31:0] lf = 32'h5DF3;
  int error_cnt = 0, n_tests = 0, cyc = 0, w, q[$];
  wire [1:0] hb = {CPU_HALT_O, BUSY_O};
  always #20 CORE_CLK_I = ~CORE_CLK_I;
  lpsr_slave #(.EXPECT(EXPECT)) dut_u (.*);
  lpsr_mst m_u (.busy_i(BUSY_O), .sck_o(SLAVE_CLOCK_IN_I),
    .sdi_o(SLAVE_DATA_IN_I));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [8:0] g, e);
    n_tests++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("BAD %0t got %h exp %h", $time, g, e);
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask : step
  task automatic give_verdict(input int hung);
    error_cnt += hung;
    $display("checks %0d bad %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // hang guard: five words need well under a thousand cycles
  always @(posedge CORE_CLK_I) if (++cyc == 2000) give_verdict(1);
  // stop request held through reset with the slow clock: must be ignored
  initial begin
    step(3);
    RST_N_I = 1;
    step(2);
    chk(hb, 9'h1);
    FAST_OSC_SEL_I = 1;
    for (int k = 0; k < 5; k++) begin
      lf = nxt(lf);
      q.push_back(k == 1 ? EXPECT : lf[7:0]);
      STOP_REQ_I = 1;
      step(1);
      STOP_REQ_I = 0;
      step(1);
      chk(hb, 9'h2);
      fork m_u.send(q[0]); join_none
      for (w = 0; RECEIVE_END_IRQ_O !== 1'h1 && w < 200; w++) step(1);
      w = q.pop_front();
      chk({RECEIVE_END_IRQ_O, RX_DATA_O}, 9'h100 | 9'(w));
      chk({CPU_HALT_O, MATCH_O}, 9'(w == EXPECT));
      WORD_READ_I = 1;
      step(1);
      WORD_READ_I = 0;
      step(1);
      chk(hb, 9'h1);
      $display("word %0d done", k);
    end
    give_verdict(0);
  end
endmodule : tb
